// ---- verilog/rx_loops_defines.svh ----
// Offsets, field positions, reset values and timing counts of the receiver loops.
`ifndef RX_LOOPS_DEFINES_SVH
`define RX_LOOPS_DEFINES_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_SIG_THR     8'h00
`define OFS_FGAIN       8'h04
`define OFS_FPERIOD     8'h08
`define OFS_FMODE       8'h0C
`define OFS_GHIGH       8'h10
`define OFS_GLOW        8'h14
`define OFS_GCTL        8'h18
`define OFS_TPOST       8'h1C
`define OFS_TGAIN_A     8'h20
`define OFS_TGAIN_B     8'h24
`define OFS_MODSEL      8'h28
`define OFS_STATUS      8'h2C
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FG_FAST         7:4
`define FG_SLOW         3:0
`define FM_EN           0
`define FM_IF           1
`define GL_SEL          7:0
`define GL_LOW0         11:8
`define GL_LOW1         15:12
`define GC_MEAS         3:0
`define GC_HOLD         11:4
`define GC_EN           12
`define GC_FRZ          13
`define TP_ORDER        0
`define TP_LONG         1
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_SIG_THR     8'h40
`define RST_FGAIN       8'h25
`define RST_FPERIOD     8'h10
`define RST_FMODE       2'h0
`define RST_GHIGH       4'h5
`define RST_GLOW        16'h4510
`define RST_GCTL        14'h00C2
`define RST_TPOST       2'h0
`define RST_TGAIN_A     3'h1
`define RST_TGAIN_B     3'h2
// ----------------------------------------------------------------------------
// Timing and gain-step figures
// ----------------------------------------------------------------------------
`define AGC_UNIT_CYC    12
`define ATT_MAX_STEPS   4'h8
`endif

// ---- verilog/rx_loops_pkg.sv ----
// Types shared by the receiver control loop modules.
package rx_loops_pkg;
   // ----------------------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {AGC_OFF, AGC_EVAL, AGC_MEAS, AGC_HOLD} agc_state_t;
   typedef enum logic [2:0] {MOD_2FSK, MOD_4FSK, MOD_2GFSK, MOD_4GFSK, MOD_AMP} mod_t;
   // ----------------------------------------------------------------------------
   // State records
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]         sig_thr;
      logic [7:0]         fgain;
      logic [7:0]         fperiod;
      logic [1:0]         fmode;
      logic [3:0]         ghigh;
      logic [15:0]        glow;
      logic [13:0]        gctl;
      logic [1:0]         tpost;
      logic [2:0]         tkp_a;
      logic [2:0]         tkp_b;
      mod_t               modsel;
      logic               dph;
      logic               dwr;
      logic               rwait;
      logic [7:0]         daddr;
      logic [31:0]        rdata;
      logic               sync_seen;
      logic               afc_on;
      logic               afc_fast;
      logic [7:0]         afc_cnt;
      logic signed [11:0] fmax;
      logic signed [11:0] fmin;
      logic signed [11:0] est;
      logic signed [11:0] slc;
      logic signed [11:0] ifc;
      logic               tim_on;
      agc_state_t         agc;
      logic [3:0]         step;
      logic [18:0]        cnt;
      logic [5:0]         atten;
   } loops_state_t;
   typedef struct packed {
      logic [2:0][11:0]   hist;
      logic [10:0]        ph;
      logic signed [7:0]  frq;
      logic               prev_sgn;
      logic               strobe;
      logic               data;
   } timing_state_t;
endpackage

// ---- verilog/symbol_timing_loop.sv ----
// Symbol timing recovery loop with first- or second-order tracking.
`timescale 1ns/1ps
module symbol_timing_loop
   import rx_loops_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   input  wire logic               run,
   input  wire logic               order_sel,
   input  wire logic               post_long,
   input  wire logic [2:0]         proportional_gain,
   input  wire logic               sample_valid,
   input  wire logic signed [11:0] freq_sample,
   output logic                    symbol_strobe,
   output logic                    symbol_data
);
   timing_state_t s_r;
   timing_state_t s_nxt;
   logic signed [13:0] filt;
   logic signed [10:0] err;
   logic [11:0]        sum;
   logic [10:0]        ph_adv;
   logic               sgn;
   logic signed [11:0] frq_new;

   // ----------------------------------------------------------------------------
   // Loop update per sample
   // ----------------------------------------------------------------------------
   // Phase is 3 integer bits of samples plus 8 fraction bits, so one symbol of
   // eight samples wraps the 11-bit phase exactly. Wrap is the expected edge.
   always_comb begin
      s_nxt   = s_r;
      filt    = '0;
      err     = $signed(s_r.ph);
      sum     = '0;
      ph_adv  = '0;
      sgn     = 1'b0;
      frq_new = '0;
      s_nxt.strobe = 1'b0;
      if (!run) begin
         s_nxt.ph  = '0;
         s_nxt.frq = '0;
      end else if (sample_valid) begin
         s_nxt.hist = {s_r.hist[1:0], freq_sample};
         // Longer averaging rejects more noise but slows the edge response.
         if (post_long) begin
            filt = (14'(freq_sample) + 14'($signed(s_r.hist[0])) +
                    14'($signed(s_r.hist[1])) + 14'($signed(s_r.hist[2]))) >>> 2;
         end else begin
            filt = (14'(freq_sample) + 14'($signed(s_r.hist[0]))) >>> 1;
         end
         sgn    = filt[13];
         sum    = {1'b0, s_r.ph} + 12'h100 + 12'(s_r.frq);
         ph_adv = sum[10:0];
         if (sgn != s_r.prev_sgn) begin
            ph_adv = sum[10:0] - 11'(err >>> proportional_gain);
            if (order_sel) begin
               frq_new = 12'(s_r.frq) + 12'(err >>> ({1'b0, proportional_gain} + 4'h4));
               if (frq_new > 12'sd64) begin
                  frq_new = 12'sd64;
               end else if (frq_new < -12'sd64) begin
                  frq_new = -12'sd64;
               end
               s_nxt.frq = frq_new[7:0];
            end
         end
         s_nxt.ph       = ph_adv;
         s_nxt.prev_sgn = sgn;
         // Mid-symbol is where the phase crosses half a symbol.
         if (!s_r.ph[10] && ph_adv[10]) begin
            s_nxt.strobe = 1'b1;
            s_nxt.data   = !sgn;
         end
      end
   end

   // State register.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign symbol_strobe = s_r.strobe;
   assign symbol_data   = s_r.data;
endmodule

// ---- verilog/rx_loops.sv ----
// Receiver frequency, gain and symbol timing control loops with AHB-Lite registers.
// Functional notes
// - Frequency loop only for FSK modulations.
// - Mode 0 slicer offset, 1 IF retune.
// - Frequency error estimate readable, fixed LSB.
// - Start fast on power; slow after period.
// - Fast and slow log2 gains, 0 to 15.
// - Fast period counted in samples, 0-255.
// - Zero period: fast until sync word.
// - Frequency loop disabled leaves signal uncorrected.
// - Attenuation in 6 dB steps, 48 dB max.
// - Peak above high raises, below low lowers.
// - High threshold field 0 to 15.
// - Per-step bit picks one of two lows.
// - Lower only after full measurement interval.
// - Hold interval after each attenuation change.
// - Above high threshold: hold interval only.
// - Below low: measure plus hold, repeat.
// - Freeze attenuation after sync when enabled.
// - Gain loop runs only when enabled.
// - Order bit selects first or second order.
// - Post-filter lengthened when bit set.
// - Timing recovery starts above power threshold.
// - First order shifts delay; gain 0-7.
`timescale 1ns/1ps
`include "rx_loops_defines.svh"
module rx_loops
   import rx_loops_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   input  wire logic [7:0]         rssi_level,
   input  wire logic               sample_valid,
   input  wire logic signed [11:0] freq_sample,
   input  wire logic [3:0]         peak_amp,
   input  wire logic               sync_detected,
   input  wire logic               rx_restart,
   output logic signed [11:0]      slicer_offset,
   output logic signed [11:0]      if_correction,
   output logic [5:0]              atten_db,
   output logic                    symbol_strobe,
   output logic                    symbol_data
);
   // ----------------------------------------------------------------------------
   // Reset image
   // ----------------------------------------------------------------------------
   localparam loops_state_t S_RST = '{
      sig_thr: `RST_SIG_THR,
      fgain:   `RST_FGAIN,
      fperiod: `RST_FPERIOD,
      fmode:   `RST_FMODE,
      ghigh:   `RST_GHIGH,
      glow:    `RST_GLOW,
      gctl:    `RST_GCTL,
      tpost:   `RST_TPOST,
      tkp_a:   `RST_TGAIN_A,
      tkp_b:   `RST_TGAIN_B,
      modsel:  MOD_2FSK,
      agc:     AGC_OFF,
      default: '0
   };

   loops_state_t       s_r;
   loops_state_t       s_nxt;
   logic               afc_ok;
   logic               pwr_above;
   logic [3:0]         afc_gain;
   logic signed [12:0] mid;
   logic signed [12:0] diff;
   logic [3:0]         low_thr;
   logic [8:0]         afc_cnt_inc;

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------
   // Measurement interval in cycles minus one: 12 * 2^field.
   function automatic logic [18:0] meas_load(input logic [3:0] mt);
      logic [18:0] cyc;
      cyc = 19'(`AGC_UNIT_CYC) << mt;
      return cyc - 19'h1;
   endfunction

   // Hold interval in cycles minus one: 12 * field, never below one cycle.
   function automatic logic [18:0] hold_load(input logic [7:0] ht);
      logic [18:0] cyc;
      cyc = 19'(ht) * 19'(`AGC_UNIT_CYC);
      return (cyc == 19'h0) ? 19'h0 : cyc - 19'h1;
   endfunction

   // Low threshold that applies while stepping down from attenuation step st.
   function automatic logic [3:0] low_of(input logic [15:0] gl, input logic [3:0] st);
      logic [2:0] idx;
      idx = 3'(st - 4'h1);
      return gl[idx] ? gl[`GL_LOW1] : gl[`GL_LOW0];
   endfunction

   // Attenuation in dB for a step count.
   function automatic logic [5:0] db_of(input logic [3:0] st);
      return ({2'h0, st} << 2) + ({2'h0, st} << 1);
   endfunction

   // True for the frequency modulation schemes.
   function automatic logic is_fsk(input mod_t m);
      return (m == MOD_2FSK) || (m == MOD_4FSK) || (m == MOD_2GFSK) || (m == MOD_4GFSK);
   endfunction

   // Register read decode; unmapped addresses read as zero.
   function automatic logic [31:0] rd_mux(input loops_state_t m, input logic [7:0] a);
      logic [31:0] d;
      d = '0;
      if (a == `OFS_SIG_THR) begin
         d = {24'h0, m.sig_thr};
      end else if (a == `OFS_FGAIN) begin
         d = {24'h0, m.fgain};
      end else if (a == `OFS_FPERIOD) begin
         d = {24'h0, m.fperiod};
      end else if (a == `OFS_FMODE) begin
         d = {30'h0, m.fmode};
      end else if (a == `OFS_GHIGH) begin
         d = {28'h0, m.ghigh};
      end else if (a == `OFS_GLOW) begin
         d = {16'h0, m.glow};
      end else if (a == `OFS_GCTL) begin
         d = {18'h0, m.gctl};
      end else if (a == `OFS_TPOST) begin
         d = {30'h0, m.tpost};
      end else if (a == `OFS_TGAIN_A) begin
         d = {29'h0, m.tkp_a};
      end else if (a == `OFS_TGAIN_B) begin
         d = {29'h0, m.tkp_b};
      end else if (a == `OFS_MODSEL) begin
         d = {29'h0, m.modsel};
      end else if (a == `OFS_STATUS) begin
         // Estimate in LSBs of fdig / (3 * 2^13).
         d = {12'h0, m.sync_seen, m.tim_on, m.afc_on, m.afc_fast,
              m.step, m.est};
      end
      return d;
   endfunction

   // ----------------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------------
   always_comb begin
      s_nxt       = s_r;
      afc_ok      = s_r.fmode[`FM_EN] && is_fsk(s_r.modsel);
      pwr_above   = rssi_level > s_r.sig_thr;
      afc_gain    = s_r.afc_fast ? s_r.fgain[`FG_FAST] : s_r.fgain[`FG_SLOW];
      mid         = (13'(s_r.fmax) + 13'(s_r.fmin)) >>> 1;
      diff        = mid - 13'(s_r.est);
      low_thr     = low_of(s_r.glow, s_r.step);
      afc_cnt_inc = {1'b0, s_r.afc_cnt} + 9'h001;

      // Bus: address phase taken while hready; reads add one wait state so
      // that a write in the preceding data phase is already visible.
      if (s_r.dph && s_r.rwait) begin
         s_nxt.rwait = 1'b0;
         s_nxt.rdata = rd_mux(s_r, s_r.daddr);
      end else if (hready) begin
         s_nxt.dph   = hsel && htrans[1];
         s_nxt.dwr   = hwrite;
         s_nxt.rwait = hsel && htrans[1] && !hwrite;
         s_nxt.daddr = haddr[7:0];
      end

      // Register writes in the data phase; unmapped writes are dropped.
      if (s_r.dph && s_r.dwr) begin
         if (s_r.daddr == `OFS_SIG_THR) begin
            s_nxt.sig_thr = hwdata[7:0];
         end else if (s_r.daddr == `OFS_FGAIN) begin
            s_nxt.fgain = hwdata[7:0];
         end else if (s_r.daddr == `OFS_FPERIOD) begin
            s_nxt.fperiod = hwdata[7:0];
         end else if (s_r.daddr == `OFS_FMODE) begin
            s_nxt.fmode = hwdata[1:0];
         end else if (s_r.daddr == `OFS_GHIGH) begin
            s_nxt.ghigh = hwdata[3:0];
         end else if (s_r.daddr == `OFS_GLOW) begin
            s_nxt.glow = hwdata[15:0];
         end else if (s_r.daddr == `OFS_GCTL) begin
            s_nxt.gctl = hwdata[13:0];
         end else if (s_r.daddr == `OFS_TPOST) begin
            s_nxt.tpost = hwdata[1:0];
         end else if (s_r.daddr == `OFS_TGAIN_A) begin
            s_nxt.tkp_a = hwdata[2:0];
         end else if (s_r.daddr == `OFS_TGAIN_B) begin
            s_nxt.tkp_b = hwdata[2:0];
         end else if (s_r.daddr == `OFS_MODSEL) begin
            s_nxt.modsel = mod_t'(hwdata[2:0]);
         end
      end

      // Sync flag: a detection in the restart cycle is kept.
      s_nxt.sync_seen = sync_detected || (s_r.sync_seen && !rx_restart);

      // Timing recovery holds off until the signal is strong enough.
      s_nxt.tim_on = pwr_above || (s_r.tim_on && !rx_restart);

      // Frequency loop.
      if (!afc_ok || rx_restart) begin
         s_nxt.afc_on   = 1'b0;
         s_nxt.afc_fast = 1'b0;
         s_nxt.afc_cnt  = '0;
         s_nxt.est      = '0;
      end else if (!s_r.afc_on) begin
         if (pwr_above) begin
            s_nxt.afc_on   = 1'b1;
            s_nxt.afc_fast = 1'b1;
            s_nxt.afc_cnt  = '0;
            s_nxt.fmax     = 12'sh800;
            s_nxt.fmin     = 12'sh7FF;
         end
      end else if (sample_valid) begin
         // Peak trackers leak toward each other so a stale extreme fades.
         if (freq_sample > s_r.fmax) begin
            s_nxt.fmax = freq_sample;
         end else if (s_r.fmax > s_r.fmin) begin
            s_nxt.fmax = s_r.fmax - 12'sd1;
         end
         if (freq_sample < s_r.fmin) begin
            s_nxt.fmin = freq_sample;
         end else if (s_r.fmin < s_r.fmax) begin
            s_nxt.fmin = s_r.fmin + 12'sd1;
         end
         s_nxt.est = s_r.est + 12'(diff >>> afc_gain);
         if (s_r.fperiod == 8'h00) begin
            s_nxt.afc_fast = !s_r.sync_seen;
         end else begin
            if (s_r.afc_cnt != 8'hFF) begin
               s_nxt.afc_cnt = afc_cnt_inc[7:0];
            end
            s_nxt.afc_fast = afc_cnt_inc < {1'b0, s_r.fperiod};
         end
      end

      // Correction routed to one path only; zero when the loop is off.
      s_nxt.slc = (afc_ok && !s_r.fmode[`FM_IF]) ? s_r.est : 12'sd0;
      s_nxt.ifc = (afc_ok && s_r.fmode[`FM_IF]) ? s_r.est : 12'sd0;

      // Gain loop. Hold keeps the chain from chasing its own settling.
      if (!s_r.gctl[`GC_EN]) begin
         s_nxt.agc  = AGC_OFF;
         s_nxt.step = '0;
         s_nxt.cnt  = '0;
      end else if (s_r.gctl[`GC_FRZ] && s_r.sync_seen) begin
         s_nxt.agc = s_r.agc;
      end else begin
         case (s_r.agc)
            AGC_OFF: begin
               s_nxt.agc = AGC_EVAL;
            end
            AGC_EVAL: begin
               if (peak_amp > s_r.ghigh) begin
                  if (s_r.step < `ATT_MAX_STEPS) begin
                     s_nxt.step = s_r.step + 4'h1;
                     s_nxt.cnt  = hold_load(s_r.gctl[`GC_HOLD]);
                     s_nxt.agc  = AGC_HOLD;
                  end
               end else if (peak_amp < low_thr && s_r.step != 4'h0) begin
                  s_nxt.cnt = meas_load(s_r.gctl[`GC_MEAS]);
                  s_nxt.agc = AGC_MEAS;
               end
            end
            AGC_MEAS: begin
               if (peak_amp >= low_thr) begin
                  s_nxt.agc = AGC_EVAL;
               end else if (s_r.cnt == 19'h0) begin
                  s_nxt.step = s_r.step - 4'h1;
                  s_nxt.cnt  = hold_load(s_r.gctl[`GC_HOLD]);
                  s_nxt.agc  = AGC_HOLD;
               end else begin
                  s_nxt.cnt = s_r.cnt - 19'h1;
               end
            end
            AGC_HOLD: begin
               if (s_r.cnt == 19'h0) begin
                  s_nxt.agc = AGC_EVAL;
               end else begin
                  s_nxt.cnt = s_r.cnt - 19'h1;
               end
            end
            default: begin
               s_nxt.agc = AGC_OFF;
            end
         endcase
      end
      s_nxt.atten = db_of(s_nxt.step);
   end

   // State register.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= S_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------
   assign hreadyout     = !(s_r.dph && s_r.rwait);
   assign hresp         = 1'b0;
   assign hrdata        = s_r.rdata;
   assign slicer_offset = s_r.slc;
   assign if_correction = s_r.ifc;
   assign atten_db      = s_r.atten;

   // Symbol timing; gain set switches at sync detection.
   symbol_timing_loop u_timing (
      .sys_clk           (sys_clk),
      .sys_rst           (sys_rst),
      .run               (s_r.tim_on),
      .order_sel         (s_r.tpost[`TP_ORDER]),
      .post_long         (s_r.tpost[`TP_LONG]),
      .proportional_gain (s_r.sync_seen ? s_r.tkp_b : s_r.tkp_a),
      .sample_valid      (sample_valid),
      .freq_sample       (freq_sample),
      .symbol_strobe     (symbol_strobe),
      .symbol_data       (symbol_data)
   );
endmodule

// ---- sim/rx_loops_props.sv ----
// Concurrent checks on the ports of the receiver loop block.
`timescale 1ns/1ps
module rx_loops_props (
   input wire logic               sys_clk,
   input wire logic               sys_rst,
   input wire logic               hsel,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic               hready,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire logic               sample_valid,
   input wire logic [5:0]         atten_db,
   input wire logic signed [11:0] slicer_offset,
   input wire logic signed [11:0] if_correction,
   input wire logic               symbol_strobe
);
   // ----
   // Bus and loop relations
   // ----
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd_taken; hsel && htrans[1] && hready && !hwrite; endsequence
   sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
   a_read_wait: assert property (s_rd_taken |=> s_one_wait)
      else $error("read data phase without one wait state");
   a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
   a_atten_range: assert property (atten_db <= 6'd48 && atten_db % 6 == 0)
      else $error("attenuation off the step grid");
   // A jump to zero is the loop being switched off, not a step.
   a_atten_onestep: assert property ($changed(atten_db) |-> atten_db == 6'd0 ||
      atten_db == $past(atten_db) + 6'd6 || atten_db + 6'd6 == $past(atten_db))
      else $error("attenuation moved by more than one step");
   a_atten_hold: assert property ($changed(atten_db) |=> $stable(atten_db))
      else $error("attenuation changed inside hold time");
   a_corr_exclusive: assert property (slicer_offset != 0 |-> if_correction == 0)
      else $error("correction applied at both places");
   a_strobe_pulse: assert property (symbol_strobe |=> !symbol_strobe)
      else $error("symbol strobe longer than one cycle");
   a_strobe_cause: assert property (symbol_strobe |-> $past(sample_valid))
      else $error("symbol strobe without a sample");
endmodule
bind rx_loops rx_loops_props rx_loops_props_inst(.sys_clk(sys_clk), .sys_rst(sys_rst),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .sample_valid(sample_valid), .atten_db(atten_db),
   .slicer_offset(slicer_offset), .if_correction(if_correction), .symbol_strobe(symbol_strobe));

// ---- sim/tx_model.sv ----
// Remote FSK transmitter as it appears at the demodulator sample outputs.
`timescale 1ns/1ps
module tx_model (
   input  wire logic signed [11:0] freq_offset,
   input  wire logic               sys_clk,
   input  wire logic [3:0]         amp_level,
   output logic                    sample_valid,
   output logic signed [11:0]      freq_sample,
   output logic [3:0]              peak_amp
);
   logic [5:0] cnt = 6'h00;
   // A sample every fourth cycle; symbols of eight samples alternate around the offset.
   // Between samples the word is inverted, so a stale value is never mistaken for data.
   always @(posedge sys_clk) begin
      cnt          <= cnt + 6'h01;
      sample_valid <= (cnt[1:0] == 2'h3);
      freq_sample  <= (cnt[1:0] == 2'h3) ? freq_offset + (cnt[5] ? 12'sd200 : -12'sd200)
                                         : ~freq_sample;
      peak_amp     <= amp_level;
   end
endmodule

// ---- sim/rx_afc_agc_timing_loops_test.sv ----
// Self-checking bench for the receiver loops with a register model.
`timescale 1ns/1ps
module rx_afc_agc_timing_loops_test;
   logic               sys_clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, sync = 1'b0;
   logic [1:0]         htrans = 2'h0;
   logic [31:0]        haddr = 32'h0, hwdata = 32'h0, seed = 32'h41D048B0, hrdata, q;
   logic [7:0]         rssi_level = 8'h00;
   logic [3:0]         amp = 4'h0, peak_amp;
   logic signed [11:0] slicer_offset, if_correction, freq_sample;
   logic               hreadyout, hresp, sample_valid, symbol_strobe, symbol_data;
   logic [5:0]         atten_db;
   int                 errors = 0, samples_checked = 0, strobes = 0, s0;
   logic [31:0]        exp_reg [11] = '{32'h40, 32'h25, 32'h10, 32'h0, 32'h5, 32'h4510,
                                        32'hC2, 32'h0, 32'h1, 32'h2, 32'h0};
   logic [31:0]        mask [11] = '{32'hFF, 32'hFF, 32'hFF, 32'h3, 32'hF, 32'hFFFF,
                                     32'h3FFF, 32'h3, 32'h7, 32'h7, 32'h7};
   // ----
   // Clock, design and far side
   // ----
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (symbol_strobe === 1'b1) strobes <= strobes + 1;
   rx_loops rx_loops_inst(.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rssi_level(rssi_level),
      .sample_valid(sample_valid), .freq_sample(freq_sample), .peak_amp(peak_amp),
      .sync_detected(sync), .rx_restart(1'b0), .slicer_offset(slicer_offset),
      .if_correction(if_correction), .atten_db(atten_db), .symbol_strobe(symbol_strobe),
      .symbol_data(symbol_data));
   tx_model tx_model_inst(.sys_clk(sys_clk), .freq_offset(12'sh064), .amp_level(amp),
      .sample_valid(sample_valid), .freq_sample(freq_sample), .peak_amp(peak_amp));
   // ----
   // Tasks
   // ----
   function automatic logic [31:0] lfsr();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // All sampling is at the rising edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      if (a < 8'h2C) exp_reg[a[7:2]] = d & mask[a[7:2]];
   endtask
   task automatic rd_chk(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
      check("register", q, (a < 8'h2C) ? exp_reg[a[7:2]] : 32'h0);
   endtask
   task automatic report_and_stop();
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 11; i++) rd_chk(8'(i * 4));
      rd_chk(8'h30);
      for (int i = 0; i < 11; i++) begin wr(8'(i * 4), lfsr()); rd_chk(8'(i * 4)); end
      wr(8'h00, 32'h40); wr(8'h04, 32'h0); wr(8'h1C, 32'h0); wr(8'h18, 32'h0);
      wr(8'h28, 32'h0); wr(8'h0C, 32'h1);
      repeat (200) @(posedge sys_clk);
      check("strobes", strobes, 0);
      check("slicer", {20'h0, slicer_offset}, 32'h0);
      rssi_level <= 8'h41;
      repeat (200) @(posedge sys_clk);
      check("slicer", 32'(slicer_offset inside {[90:110]}), 1);
      check("if", {20'h0, if_correction}, 32'h0);
      check("strobes", 32'(strobes > 0), 32'h1);
      bus(1'b0, 8'h2C, 32'h0);
      check("estimate", 32'($signed(q[11:0]) inside {[90:110]}), 1);
      s0 = strobes;
      wr(8'h1C, 32'h3);
      repeat (400) @(posedge sys_clk);
      check("strobes", 32'(strobes > s0), 32'h1);
      wr(8'h0C, 32'h3);
      for (int m = 0; m < 5; m++) begin
         wr(8'h28, m);
         repeat (100) @(posedge sys_clk);
         check("if", 32'(m < 4 ? if_correction inside {[90:110]} : !if_correction), 1);
         check("slicer", {20'h0, slicer_offset}, 32'h0);
      end
      wr(8'h28, 32'h0); wr(8'h0C, 32'h2);
      repeat (20) @(posedge sys_clk);
      check("if", {20'h0, if_correction}, 32'h0);
      wr(8'h10, 32'h5); wr(8'h14, 32'h4510);
      amp <= 4'hF;
      wr(8'h18, 32'h1010);
      repeat (300) @(posedge sys_clk);
      check("atten", atten_db, 32'd48);
      amp <= 4'h0;
      repeat (6) @(posedge sys_clk);
      check("atten", atten_db, 32'd48);
      repeat (500) @(posedge sys_clk);
      check("atten", atten_db, 32'd0);
      wr(8'h18, 32'h0010);
      amp <= 4'hF;
      repeat (50) @(posedge sys_clk);
      check("atten", atten_db, 32'd0);
      sync <= 1'b1; wr(8'h18, 32'h3010);
      repeat (50) @(posedge sys_clk);
      check("atten", atten_db, 32'd0);
      report_and_stop();
   end
   // A stuck handshake or loop ends the run as a failure.
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      report_and_stop();
   end
endmodule
